/* src/asrc_ctrl_pkg.sv */
// Constants, types and register map for the converter control block
package asrc_ctrl_pkg;
    // Clock period and timing resolution
    localparam int CLK_PS = 20000;
    localparam int RES_PS = 5;
    localparam int FRAC = 12;
    localparam int SETTLE_RAW = (RES_PS * (2 ** FRAC)) / CLK_PS;
    localparam int SETTLE_LSB = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
    // Estimate widths and loop gains
    localparam int PW = 16;
    localparam int EW = PW + FRAC;
    localparam int FAST_SHIFT = 4;
    localparam int SLOW_SHIFT = 15;
    localparam int AW = EW + SLOW_SHIFT;
    localparam int PHASE_W = 20;
    localparam int DIV_CW = 5;
    // Fast mode exit, rate change and hysteresis settings
    localparam logic [EW-1:0] FAST_EXIT = EW'(2 ** FRAC);
    localparam logic [EW-1:0] RATE_LIM = EW'(4 * (2 ** FRAC));
    localparam logic [4:0] FAST_HOLD = 5'h10;
    localparam int HYST_SHIFT = 4;
    localparam int LEN_W = 4;
    localparam logic [LEN_W-1:0] LEN_MIN = 4'h1;
    localparam logic [LEN_W-1:0] LEN_MAX = 4'h8;
    // Soft mute ramp
    localparam int RAMP_TICK_NS = 20480;
    localparam int RAMP_TICK_CYC = (RAMP_TICK_NS * 1000) / CLK_PS;
    localparam int TICK_W = 11;
    localparam int GAIN_W = 8;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hFF;
    // Write pointer offsets
    localparam int PTR_W = 9;
    localparam logic [PTR_W-1:0] OFS_SHORT = 9'h010;
    localparam logic [PTR_W-1:0] OFS_LONG = 9'h040;
    localparam logic [PTR_W-1:0] DELAY_DIFF = OFS_LONG - OFS_SHORT;
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_IN_PERIOD = 8'h10;
    localparam logic [ADDR_W-1:0] REG_OUT_PERIOD = 8'h14;
    localparam logic [ADDR_W-1:0] REG_PHASE = 8'h18;
    localparam int EV_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Servo loop modes
    typedef enum logic {SERVO_FAST, SERVO_SLOW} servo_mode_t;
endpackage

/* src/asrc_servo_mute_delay_ctrl.sv */
// Servo, mute, ratio, delay offset and bypass control for the converter
//
// Function
// - Measure input/output timing to 5 ps
// - Servo rejects jitter, corner below 1 Hz
// - Reset or rate change enters fast settling
// - Settled fast goes slow, settles to 5 ps
// - Mute flag high throughout fast settling
// - Soft mute request ramps output down/up
// - Ratio scales FIR length when decimating
// - Ratio hysteresis stops filter length oscillation
// - Phase match: master sends, slaves use ratio
// - Write pointer offset 16 short, 64 long
// - Long delay adds 48 input sample periods
// - Bypass passes serial data, no dither
// - Output picks preceding one of 2^20 interpolated points
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module asrc_servo_mute_delay_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous pins
    input wire logic lrclk_in,
    input wire logic lrclk_out,
    input wire logic sdata_in,
    input wire logic mute_req,
    input wire logic group_delay_select,
    input wire logic bypass,
    input wire logic [asrc_ctrl_pkg::LEN_W-1:0] ratio_rx,
    input wire logic ratio_rx_toggle,
    // Converted data from filter
    input wire logic conv_sdata,
    // Control outputs
    output logic mute_flag,
    output logic sdata_out,
    output logic dither_en,
    output logic [asrc_ctrl_pkg::PTR_W-1:0] fifo_wr_addr,
    output logic [asrc_ctrl_pkg::PHASE_W-1:0] rom_phase,
    output logic [asrc_ctrl_pkg::LEN_W-1:0] conv_len,
    output logic [asrc_ctrl_pkg::GAIN_W-1:0] ramp_gain,
    output logic [asrc_ctrl_pkg::LEN_W-1:0] ratio_tx,
    output logic ratio_tx_toggle,
    output logic irq,
    // AXI4-Lite slave
    input wire logic [asrc_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [asrc_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import asrc_ctrl_pkg::*;

    // Advance a period estimate by a shifted error; guard bits keep slow steps
    function automatic logic [AW-1:0] servo_step(input logic [AW-1:0] acc,
            input logic [PW-1:0] meas, input logic fast);
        logic signed [AW:0] err;
        err = $signed({1'b0, meas, {(FRAC + SLOW_SHIFT){1'b0}}}) - $signed({1'b0, acc});
        if (fast) begin
            err = err >>> FAST_SHIFT;
        end else begin
            err = err >>> SLOW_SHIFT;
        end
        return acc + err[AW-1:0];
    endfunction

    // Magnitude of measured period minus estimate
    function automatic logic [EW-1:0] err_mag(input logic [EW-1:0] est,
            input logic [PW-1:0] meas);
        logic [EW-1:0] m;
        m = {meas, {FRAC{1'b0}}};
        return (m >= est) ? m - est : est - m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: first stage read only by second
    logic [2:0] lri_r, lro_r, rxt_r;
    logic [1:0] mute_s_r, sdi_s_r, gds_s_r, byp_s_r;
    logic [LEN_W-1:0] rxd_s1_r, rxd_s2_r;

    // Two flops per pin, third stage only for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lri_r <= '0;
            lro_r <= '0;
            rxt_r <= '0;
            mute_s_r <= 2'h3; // Muted through reset, no false unmute step
            sdi_s_r <= '0;
            gds_s_r <= '0;
            byp_s_r <= '0;
            rxd_s1_r <= '0;
            rxd_s2_r <= '0;
        end else begin
            lri_r <= {lri_r[1:0], lrclk_in};
            lro_r <= {lro_r[1:0], lrclk_out};
            rxt_r <= {rxt_r[1:0], ratio_rx_toggle};
            mute_s_r <= {mute_s_r[0], mute_req};
            sdi_s_r <= {sdi_s_r[0], sdata_in};
            gds_s_r <= {gds_s_r[0], group_delay_select};
            byp_s_r <= {byp_s_r[0], bypass};
            rxd_s1_r <= ratio_rx;
            rxd_s2_r <= rxd_s1_r;
        end
    end

    // Sample instants and synced levels
    logic in_edge, out_edge, rx_new, gds, byp;
    assign in_edge = lri_r[1] & ~lri_r[2];
    assign out_edge = lro_r[1] & ~lro_r[2];
    assign rx_new = rxt_r[1] ^ rxt_r[2];
    assign gds = gds_s_r[1];
    assign byp = byp_s_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Core state
    servo_mode_t mode_r, mode_nxt;
    logic [PW-1:0] in_cnt_r, in_cnt_nxt, out_cnt_r, out_cnt_nxt;
    logic [AW-1:0] in_acc_r, in_acc_nxt, out_acc_r, out_acc_nxt;
    logic [EW-1:0] in_mag_r, in_mag_nxt, den_r, den_nxt;
    logic [EW:0] rem_r, rem_nxt;
    logic [PHASE_W-1:0] quo_r, quo_nxt, phase_r, phase_nxt;
    logic [DIV_CW-1:0] div_cnt_r, div_cnt_nxt;
    logic div_busy_r, div_busy_nxt, settled_r, settled_nxt;
    logic [4:0] hold_r, hold_nxt;
    logic [LEN_W-1:0] len_r, len_nxt, rx_len_r, rx_len_nxt, clen_r, clen_nxt;
    logic [LEN_W-1:0] tx_r, tx_nxt;
    logic tx_tog_r, tx_tog_nxt, gds_q_r, byp_q_r;
    logic [PTR_W-1:0] wptr_r, wptr_nxt, waddr_r, waddr_nxt;
    logic [TICK_W-1:0] tick_r, tick_nxt;
    logic [GAIN_W-1:0] gain_r, gain_nxt;
    logic sdo_r, sdo_nxt, dith_r, dith_nxt, mflag_r;
    logic [EV_W-1:0] ev;
    logic [31:0] ctrl_r;
    // Working terms
    logic [EW-1:0] in_est, out_est, out_mag;
    logic [PW+LEN_W-1:0] in_int, out_int, hyst, prod_up, prod_dn;
    logic restart, fast;
    logic [EW:0] rem_sh;

    // Next-state for servo, ratio, divider, pointer, mute and bypass
    always_comb begin
        mode_nxt = mode_r;
        settled_nxt = settled_r;
        hold_nxt = hold_r;
        in_acc_nxt = in_acc_r;
        out_acc_nxt = out_acc_r;
        in_mag_nxt = in_mag_r;
        len_nxt = len_r;
        rx_len_nxt = rx_len_r;
        tx_nxt = tx_r;
        tx_tog_nxt = tx_tog_r;
        rem_nxt = rem_r;
        den_nxt = den_r;
        quo_nxt = quo_r;
        phase_nxt = phase_r;
        div_cnt_nxt = div_cnt_r;
        div_busy_nxt = div_busy_r;
        wptr_nxt = wptr_r;
        ev = '0;
        fast = (mode_r == SERVO_FAST);
        in_est = in_acc_r[AW-1 -: EW];
        out_est = out_acc_r[AW-1 -: EW];
        out_mag = err_mag(out_est, out_cnt_r);
        // Coarse periods: counts between sample instants
        in_cnt_nxt = in_edge ? PW'(1) : in_cnt_r + PW'(in_cnt_r != '1);
        out_cnt_nxt = out_edge ? PW'(1) : out_cnt_r + PW'(out_cnt_r != '1);
        // Averaging servo with fast and slow gains
        if (in_edge) begin
            in_acc_nxt = servo_step(in_acc_r, in_cnt_r, fast);
            in_mag_nxt = err_mag(in_est, in_cnt_r);
        end
        if (out_edge) begin
            out_acc_nxt = servo_step(out_acc_r, out_cnt_r, fast);
        end
        // Resettle on rate jump or live mode pin change
        restart = (gds != gds_q_r) || (byp != byp_q_r);
        if (!fast && ((in_edge && err_mag(in_est, in_cnt_r) > RATE_LIM)
                || (out_edge && out_mag > RATE_LIM))) begin
            restart = 1'b1;
        end
        if (restart) begin
            mode_nxt = SERVO_FAST;
            settled_nxt = 1'b0;
            hold_nxt = '0;
            ev[0] = 1'b1;
        end else if (out_edge) begin
            if (fast) begin
                // Leave fast mode after a run of small errors
                if (in_mag_r < FAST_EXIT && out_mag < FAST_EXIT) begin
                    hold_nxt = hold_r + 5'h01;
                end else begin
                    hold_nxt = '0;
                end
                if (hold_r == FAST_HOLD - 5'h01) begin
                    mode_nxt = SERVO_SLOW;
                end
            end else if (!settled_r && (in_mag_r >> SLOW_SHIFT) <= EW'(SETTLE_LSB)
                    && (out_mag >> SLOW_SHIFT) <= EW'(SETTLE_LSB)) begin
                settled_nxt = 1'b1;
                ev[1] = 1'b1;
            end
        end
        // Filter length from ratio with hysteresis band
        in_int = (PW + LEN_W)'(in_acc_r[AW-1 -: PW]);
        out_int = (PW + LEN_W)'(out_acc_r[AW-1 -: PW]);
        hyst = in_int >> HYST_SHIFT;
        prod_up = in_int * (PW + LEN_W)'(len_r);
        prod_dn = in_int * (PW + LEN_W)'(len_r - LEN_MIN);
        if (out_edge) begin
            if (out_int > prod_up + hyst && len_r < LEN_MAX) begin
                len_nxt = len_r + LEN_MIN;
                ev[2] = 1'b1;
            end else if (len_r > LEN_MIN && out_int + hyst < prod_dn) begin
                len_nxt = len_r - LEN_MIN;
                ev[2] = 1'b1;
            end
        end
        // Phase matching: master sends, slave adopts received length
        if (rx_new) begin
            rx_len_nxt = rxd_s2_r;
        end
        if (ctrl_r[0] && ctrl_r[1] && tx_r != len_r) begin
            tx_nxt = len_r;
            tx_tog_nxt = ~tx_tog_r;
        end
        clen_nxt = (ctrl_r[0] && !ctrl_r[1]) ? rx_len_r : len_r;
        // Preceding interpolated point: elapsed/period in 2^20 steps, truncated
        rem_sh = {rem_r[EW-1:0], 1'b0};
        if (div_busy_r) begin
            if (rem_sh >= {1'b0, den_r}) begin
                rem_nxt = rem_sh - {1'b0, den_r};
                quo_nxt = {quo_r[PHASE_W-2:0], 1'b1};
            end else begin
                rem_nxt = rem_sh;
                quo_nxt = {quo_r[PHASE_W-2:0], 1'b0};
            end
            div_cnt_nxt = div_cnt_r - DIV_CW'(1);
            if (div_cnt_r == DIV_CW'(1)) begin
                div_busy_nxt = 1'b0;
                phase_nxt = quo_nxt;
            end
        end else if (out_edge) begin
            den_nxt = (in_est == '0) ? EW'(1) : in_est;
            rem_nxt = {1'b0, in_cnt_r, {FRAC{1'b0}}};
            quo_nxt = '0;
            if ({in_cnt_r, {FRAC{1'b0}}} >= den_nxt) begin
                phase_nxt = '1;
            end else begin
                div_busy_nxt = 1'b1;
                div_cnt_nxt = DIV_CW'(PHASE_W);
            end
        end
        // Write pointer plus delay offset
        if (in_edge) begin
            wptr_nxt = wptr_r + PTR_W'(1);
        end
        waddr_nxt = wptr_r + (gds ? OFS_SHORT : OFS_LONG);
        // Soft mute ramp, one step per tick
        tick_nxt = (tick_r == TICK_W'(RAMP_TICK_CYC - 1)) ? '0 : tick_r + TICK_W'(1);
        gain_nxt = gain_r;
        if (tick_r == '0) begin
            if (mute_s_r[1] && gain_r != '0) begin
                gain_nxt = gain_r - GAIN_W'(1);
            end else if (!mute_s_r[1] && gain_r != GAIN_MAX) begin
                gain_nxt = gain_r + GAIN_W'(1);
            end
        end
        // Bypass sends input straight out undithered
        sdo_nxt = byp ? sdi_s_r[1] : conv_sdata;
        dith_nxt = !byp;
    end

    // Core registers; reset puts servo in fast mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= SERVO_FAST;
            settled_r <= 1'b0;
            hold_r <= '0;
            in_cnt_r <= '0;
            out_cnt_r <= '0;
            in_acc_r <= '0;
            out_acc_r <= '0;
            in_mag_r <= '1;
            len_r <= LEN_MIN;
            rx_len_r <= LEN_MIN;
            clen_r <= LEN_MIN;
            tx_r <= LEN_MIN;
            tx_tog_r <= 1'b0;
            rem_r <= '0;
            den_r <= '0;
            quo_r <= '0;
            phase_r <= '0;
            div_cnt_r <= '0;
            div_busy_r <= 1'b0;
            wptr_r <= '0;
            waddr_r <= '0;
            tick_r <= '0;
            gain_r <= '0;
            sdo_r <= 1'b0;
            dith_r <= 1'b0;
            mflag_r <= 1'b1;
            gds_q_r <= 1'b0;
            byp_q_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            settled_r <= settled_nxt;
            hold_r <= hold_nxt;
            in_cnt_r <= in_cnt_nxt;
            out_cnt_r <= out_cnt_nxt;
            in_acc_r <= in_acc_nxt;
            out_acc_r <= out_acc_nxt;
            in_mag_r <= in_mag_nxt;
            len_r <= len_nxt;
            rx_len_r <= rx_len_nxt;
            clen_r <= clen_nxt;
            tx_r <= tx_nxt;
            tx_tog_r <= tx_tog_nxt;
            rem_r <= rem_nxt;
            den_r <= den_nxt;
            quo_r <= quo_nxt;
            phase_r <= phase_nxt;
            div_cnt_r <= div_cnt_nxt;
            div_busy_r <= div_busy_nxt;
            wptr_r <= wptr_nxt;
            waddr_r <= waddr_nxt;
            tick_r <= tick_nxt;
            gain_r <= gain_nxt;
            sdo_r <= sdo_nxt;
            dith_r <= dith_nxt;
            mflag_r <= (mode_nxt == SERVO_FAST);
            gds_q_r <= gds;
            byp_q_r <= byp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus state
    logic awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
    logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, irq_r, irq_nxt;
    logic [ADDR_W-1:0] aw_a_r, aw_a_nxt;
    logic [31:0] w_d_r, w_d_nxt, rd_r, rd_nxt, ctrl_nxt;
    logic [3:0] w_s_r, w_s_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic [EV_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, w1c;

    // Write and read channels, status and interrupt
    always_comb begin
        aw_h_nxt = aw_h_r || (s_axi_awvalid && awr_r);
        aw_a_nxt = (s_axi_awvalid && awr_r) ? s_axi_awaddr : aw_a_r;
        w_h_nxt = w_h_r || (s_axi_wvalid && wr_r);
        w_d_nxt = (s_axi_wvalid && wr_r) ? s_axi_wdata : w_d_r;
        w_s_nxt = (s_axi_wvalid && wr_r) ? s_axi_wstrb : w_s_r;
        bv_nxt = bv_r && !s_axi_bready;
        br_nxt = br_r;
        ctrl_nxt = ctrl_r;
        imask_nxt = imask_r;
        w1c = '0;
        if (aw_h_r && w_h_r && !bv_r) begin
            aw_h_nxt = 1'b0;
            w_h_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = RESP_OKAY;
            unique case (aw_a_r)
                REG_CTRL: if (w_s_r[0]) ctrl_nxt = {30'h0000_0000, w_d_r[1:0]};
                REG_INT_STAT: if (w_s_r[0]) w1c = w_d_r[EV_W-1:0];
                REG_INT_MASK: if (w_s_r[0]) imask_nxt = w_d_r[EV_W-1:0];
                REG_STATUS, REG_IN_PERIOD, REG_OUT_PERIOD, REG_PHASE: br_nxt = RESP_OKAY;
                default: br_nxt = RESP_SLVERR;
            endcase
        end
        awr_nxt = !aw_h_nxt && !bv_nxt;
        wr_nxt = !w_h_nxt && !bv_nxt;
        // Hardware set wins over write-one clear
        ist_nxt = (ist_r & ~w1c) | ev;
        irq_nxt = |(ist_nxt & imask_nxt);
        rv_nxt = rv_r && !s_axi_rready;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        if (s_axi_arvalid && arr_r) begin
            rv_nxt = 1'b1;
            rr_nxt = RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: rd_nxt = ctrl_r;
                REG_STATUS: rd_nxt = {24'h00_0000, clen_r, byp, gds, settled_r,
                        mode_r == SERVO_FAST};
                REG_INT_STAT: rd_nxt = 32'(ist_r);
                REG_INT_MASK: rd_nxt = 32'(imask_r);
                REG_IN_PERIOD: rd_nxt = 32'(in_est);
                REG_OUT_PERIOD: rd_nxt = 32'(out_est);
                REG_PHASE: rd_nxt = 32'(phase_r);
                default: begin
                    rd_nxt = 32'h0000_0000;
                    rr_nxt = RESP_SLVERR;
                end
            endcase
        end
        arr_nxt = !rv_nxt;
    end

    // Bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_r <= 1'b0;
            wr_r <= 1'b0;
            bv_r <= 1'b0;
            br_r <= RESP_OKAY;
            arr_r <= 1'b0;
            rv_r <= 1'b0;
            rr_r <= RESP_OKAY;
            rd_r <= '0;
            aw_h_r <= 1'b0;
            aw_a_r <= '0;
            w_h_r <= 1'b0;
            w_d_r <= '0;
            w_s_r <= '0;
            ctrl_r <= '0;
            ist_r <= '0;
            imask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            awr_r <= awr_nxt;
            wr_r <= wr_nxt;
            bv_r <= bv_nxt;
            br_r <= br_nxt;
            arr_r <= arr_nxt;
            rv_r <= rv_nxt;
            rr_r <= rr_nxt;
            rd_r <= rd_nxt;
            aw_h_r <= aw_h_nxt;
            aw_a_r <= aw_a_nxt;
            w_h_r <= w_h_nxt;
            w_d_r <= w_d_nxt;
            w_s_r <= w_s_nxt;
            ctrl_r <= ctrl_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs straight from flops
    assign mute_flag = mflag_r;
    assign sdata_out = sdo_r;
    assign dither_en = dith_r;
    assign fifo_wr_addr = waddr_r;
    assign rom_phase = phase_r;
    assign conv_len = clen_r;
    assign ramp_gain = gain_r;
    assign ratio_tx = tx_r;
    assign ratio_tx_toggle = tx_tog_r;
    assign irq = irq_r;
    assign s_axi_awready = awr_r;
    assign s_axi_wready = wr_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = br_r;
    assign s_axi_arready = arr_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rr_r;
endmodule
`default_nettype wire

/* verif/asrc_far_side.sv */
// Far side model: sample clocks, serial data, ratio sender
`timescale 1ns/10ps
`default_nettype none
module asrc_far_side (
    // Sample clocks and data
    output logic lrclk_in,
    output logic lrclk_out,
    output logic sdata_in,
    // Ratio link from a chain master
    output logic [asrc_ctrl_pkg::LEN_W-1:0] ratio_rx,
    output logic ratio_rx_toggle
);
    import asrc_ctrl_pkg::*;
    bit run_in = 1'b1;
    // Input frames of 800 ns; frozen low while run_in is low
    initial begin
        lrclk_in = 1'b0;
        forever #400 lrclk_in = run_in & ~lrclk_in;
    end
    // Output frames of 1020 ns, phase unrelated to aclk
    initial begin
        lrclk_out = 1'b0;
        #137;
        forever #510 lrclk_out = ~lrclk_out;
    end
    // Data changes every slot so a stale bit shows
    initial begin
        sdata_in = 1'b0;
        ratio_rx = 4'h1;
        ratio_rx_toggle = 1'b0;
        #5; // Keeps data edges off the aclk edges
        forever #70 sdata_in = ~sdata_in;
    end
    // Ratio settles well before its toggle flips
    task automatic send(input logic [LEN_W-1:0] v);
        ratio_rx = v;
        #100 ratio_rx_toggle = ~ratio_rx_toggle;
    endtask
endmodule
`default_nettype wire

/* verif/asrc_servo_mute_delay_ctrl_bench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module asrc_servo_mute_delay_ctrl_bench;
    import asrc_ctrl_pkg::*;
    logic aclk, aresetn, lrclk_in, lrclk_out, sdata_in, mute_req, group_delay_select, bypass;
    logic ratio_rx_toggle, conv_sdata, mute_flag, sdata_out, dither_en, ratio_tx_toggle, irq;
    logic [LEN_W-1:0] ratio_rx, conv_len, ratio_tx;
    logic [PTR_W-1:0] fifo_wr_addr, a0;
    logic [PHASE_W-1:0] rom_phase;
    logic [GAIN_W-1:0] ramp_gain, g0;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hold_mute;
    int errors, num_checks, t;
    // Mute flag looped to the request, as a system would wire it
    assign mute_req = mute_flag | hold_mute;
    asrc_servo_mute_delay_ctrl i_dut (.*);
    asrc_far_side i_far (.*);
    ////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) conv_sdata <= ~conv_sdata;
    // Compare, counting every check
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Write: address and data together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Bounded wait for the servo to leave fast mode
    task automatic settle;
        for (t = 0; mute_flag !== 1'b0 && t < 30000; t++) @(posedge aclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard at 1 ms, well above the expected run
    initial begin
        #1000000;
        errors++;
        give_verdict();
    end
    initial begin
        {errors, num_checks, hold_mute, aresetn, bypass, conv_sdata} = '0;
        {group_delay_select, s_axi_wstrb} = 5'h1f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        chk("mute", 1, mute_flag);
        chk("gain", 0, ramp_gain);
        rd_reg(REG_STATUS);
        chk("fast", 1, rd[0]);
        rd_reg(8'h40);
        chk("rresp", {30'h0, RESP_SLVERR}, {rd[29:0], rsp});
        wr(8'h40, 32'h0000_0001);
        chk("bresp", RESP_SLVERR, rsp);
        $display("test reset done");
        settle();
        chk("mute", 0, mute_flag);
        chk("len", 2, conv_len);
        wr(REG_INT_STAT, 32'h0000_0007);
        i_far.run_in = 1'b0;
        tick(8);
        a0 = fifo_wr_addr;
        group_delay_select <= 1'b0;
        tick(8);
        chk("ofs", 9'(a0 + 9'h030), fifo_wr_addr);
        chk("mute", 1, mute_flag);
        rd_reg(REG_INT_STAT);
        chk("entry", 1, rd[0]);
        chk("irq", 0, irq);
        wr(REG_INT_MASK, 32'h0000_0001);
        chk("irq", 1, irq);
        wr(REG_INT_STAT, 32'h0000_0001);
        chk("irq", 0, irq);
        i_far.run_in = 1'b1;
        group_delay_select <= 1'b1;
        $display("test delay done");
        bypass <= 1'b1;
        tick(8);
        chk("dither", 0, dither_en);
        bypass <= 1'b0;
        tick(8);
        chk("dither", 1, dither_en);
        settle();
        chk("mute", 0, mute_flag);
        wr(REG_CTRL, 32'h0000_0001);
        i_far.send(4'h5);
        tick(10);
        chk("rxlen", 5, conv_len);
        wr(REG_CTRL, 32'h0000_0003);
        tick(10);
        chk("txlen", 2, ratio_tx);
        chk("txtog", 1, ratio_tx_toggle);
        $display("test modes done");
        g0 = ramp_gain;
        tick(2100);
        chk("up", 1, ramp_gain >= g0 + 8'h02);
        hold_mute <= 1'b1;
        g0 = ramp_gain;
        tick(2100);
        chk("down", 1, ramp_gain + 8'h02 <= g0);
        $display("test mute done");
        give_verdict();
    end
endmodule
`default_nettype wire

/* verif/asrc_servo_mute_delay_ctrl_sva.sv */
// Assertion checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module asrc_ctrl_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control pins
    input wire logic mute_flag,
    input wire logic mute_req,
    input wire logic bypass,
    input wire logic dither_en,
    input wire logic sdata_in,
    input wire logic sdata_out,
    input wire logic [asrc_ctrl_pkg::LEN_W-1:0] conv_len,
    input wire logic [asrc_ctrl_pkg::GAIN_W-1:0] ramp_gain,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    import asrc_ctrl_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // Both write halves taken on one edge
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_mute_in_reset: assert property (disable iff (1'b0) !aresetn |=> mute_flag)
        else $error("mute flag low after reset");
    a_bypass_no_dither: assert property (bypass [*6] |-> !dither_en)
        else $error("dither on in bypass");
    a_bypass_data_path: assert property (bypass [*6] |-> sdata_out == $past(sdata_in, 3))
        else $error("bypass data not passed");
    a_len_in_range: assert property (conv_len >= LEN_MIN && conv_len <= LEN_MAX)
        else $error("filter length out of range");
    a_ramp_single_step: assert property ($past(aresetn) && $changed(ramp_gain) |->
        (ramp_gain - $past(ramp_gain) == 8'h01 || $past(ramp_gain) - ramp_gain == 8'h01))
        else $error("gain jumped");
    a_mute_no_rise: assert property (mute_req [*4] |=> ramp_gain <= $past(ramp_gain))
        else $error("gain rose while muted");
    a_write_resp_time: assert property (both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_ready_while_resp: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
endmodule
bind asrc_servo_mute_delay_ctrl asrc_ctrl_sva i_sva (.*);
`default_nettype wire
